/* hw/imc_line_filter.sv */
// Pin synchroniser with optional glitch filter for both bus lines
`timescale 1ns/1ps
`default_nettype none
module imc_line_filter
  import imc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic filt_on_in,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  imc_line_if.src line
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] stable_r;
  logic [3:0] cnt_r [2];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
    end else if (ce_in) begin
      meta_r <= {scl_pin_in, sda_pin_in};
      sync_r <= meta_r;
    end
  end

  // A change must persist for the whole window before it is accepted
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stable_r <= 2'h3;
      cnt_r[0] <= 4'h0;
      cnt_r[1] <= 4'h0;
    end else if (ce_in) begin
      for (int i = 0; i < 2; i++) begin
        if (!filt_on_in) begin // RULE4
          stable_r[i] <= sync_r[i];
          cnt_r[i] <= 4'h0;
        end else if (sync_r[i] == stable_r[i]) begin
          cnt_r[i] <= 4'h0;
        end else if (cnt_r[i] == 4'(FILT_CYC - 1)) begin // RULE4
          stable_r[i] <= sync_r[i];
          cnt_r[i] <= 4'h0;
        end else begin
          cnt_r[i] <= cnt_r[i] + 4'h1;
        end
      end
    end
  end

  assign line.scl = stable_r[1];
  assign line.sda = stable_r[0];
endmodule
`default_nettype wire

/* hw/imc_line_if.sv */
// Synchronised and filtered bus line levels
`timescale 1ns/1ps
`default_nettype none
interface imc_line_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface
`default_nettype wire

/* hw/imc_master_top.sv */
// Register-controlled two-wire bus master
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Enable register bit 0 turns the master on, reset clears it.
// RULE2: Control bit 9 reads 1 while a receive is pending or running.
// RULE3: Control bit 8 reads 1 while a transmit is pending or running.
// RULE4: Control bit 4 switches the input glitch filter, reset off.
// RULE5: Writing 1 to control bit 1 requests a stop condition.
// RULE6: Writing 1 to control bit 0 requests a start condition.
// RULE7: Data bit 11 reads 1 while a received byte waits.
// RULE8: Writing 1 to data bit 10 starts reception of one byte.
// RULE9: Writing 1 to data bit 9 starts transmission of the byte field.
// RULE10: Data bit 8 is the acknowledge, 0 meaning acknowledge.
// RULE11: Data bits 7 to 0 hold the byte, most significant bit first.
// RULE12: Interrupt control bit 1 enables the receive interrupt.
// RULE13: Interrupt control bit 0 enables the transmit interrupt.
// RULE14: All unused register bits read as zero.
// RULE15: Transmit and receive completion raise their interrupts.
// RULE16: Lines are open drain, acknowledge sampled on the ninth clock.
module imc_master_top
  import imc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  imc_line_if line ();

  logic master_on_r;
  logic filt_on_r;
  logic start_req_r;
  logic stop_req_r;
  logic tx_req_r;
  logic rx_req_r;
  logic ack_bit_r;
  logic [7:0] byte_r;
  logic rx_rdy_r;
  logic [1:0] irq_en_r;
  logic [1:0] irq_stat_r;
  logic irq_r;
  logic [15:0] rdata_r;
  imc_state_t state_r;
  logic [1:0] phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic is_rx_r;
  logic ack_in_r;
  logic scl_low_r;
  logic sda_low_r;
  logic tick;
  logic idle;
  logic go_start;
  logic go_tx;
  logic go_rx;
  logic go_stop;
  logic byte_fin;
  logic tx_fin;
  logic rx_fin;
  logic tx_busy;
  logic rx_busy;
  logic wr_en;
  logic wr_ctl;
  logic wr_dat;
  logic rd_dat;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] t);
    hit = (a == t);
  endfunction

  function automatic logic [15:0] read_word(input logic [15:0] a);
    read_word = 16'h0000; // RULE14
    if (hit(a, ADDR_ENABLE)) begin
      read_word[EN_ON_BIT] = master_on_r;
    end else if (hit(a, ADDR_CONTROL)) begin
      read_word[CTL_RXBUSY_BIT] = rx_busy; // RULE2
      read_word[CTL_TXBUSY_BIT] = tx_busy; // RULE3
      read_word[CTL_FILT_BIT] = filt_on_r;
      read_word[CTL_STOP_BIT] = stop_req_r || (state_r == ST_STOP);
      read_word[CTL_START_BIT] = start_req_r || (state_r == ST_START);
    end else if (hit(a, ADDR_DATA)) begin
      read_word[DAT_RDY_BIT] = rx_rdy_r; // RULE7
      read_word[DAT_RXE_BIT] = rx_busy;
      read_word[DAT_TXE_BIT] = tx_busy;
      read_word[DAT_ACK_BIT] = ack_bit_r;
      read_word[7:0] = byte_r;
    end else if (hit(a, ADDR_ICTL)) begin
      read_word[1:0] = irq_en_r;
    end else if (hit(a, ADDR_STATUS)) begin
      read_word[1:0] = irq_stat_r;
    end
  endfunction

  imc_line_filter u_filter (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .filt_on_in(filt_on_r),
    .scl_pin_in(scl_in),
    .sda_pin_in(sda_in),
    .line(line.src)
  );

  // A released clock held low by a slave stretches the bit
  imc_quarter_timer u_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .run_in(!idle),
    .hold_in(!scl_low_r && !line.scl),
    .tick_out(tick)
  );

  assign wr_en = wr_in && ce_in;
  assign wr_ctl = wr_en && hit(addr_in, ADDR_CONTROL);
  assign wr_dat = wr_en && hit(addr_in, ADDR_DATA);
  assign rd_dat = rd_in && ce_in && hit(addr_in, ADDR_DATA);

  assign idle = (state_r == ST_IDLE);
  // Start first, then data, stop last, so requests queued by separate writes run in that order
  assign go_start = ce_in && idle && master_on_r && start_req_r;
  assign go_tx = ce_in && idle && master_on_r && !start_req_r && tx_req_r;
  assign go_rx = ce_in && idle && master_on_r && !start_req_r &&
                 !tx_req_r && rx_req_r;
  assign go_stop = ce_in && idle && master_on_r && !start_req_r &&
                   !tx_req_r && !rx_req_r && stop_req_r;
  assign byte_fin = tick && (state_r == ST_BITS) && (phase_r == 2'd3) &&
                    (bit_cnt_r == 4'(LAST_BIT));
  assign tx_fin = byte_fin && !is_rx_r;
  assign rx_fin = byte_fin && is_rx_r;
  assign tx_busy = tx_req_r || ((state_r == ST_BITS) && !is_rx_r);
  assign rx_busy = rx_req_r || ((state_r == ST_BITS) && is_rx_r);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      master_on_r <= 1'b0;
      filt_on_r <= 1'b0;
      irq_en_r <= IRQ_RESET;
    end else if (ce_in) begin
      if (wr_en && hit(addr_in, ADDR_ENABLE)) begin
        master_on_r <= wdata_in[EN_ON_BIT]; // RULE1
      end
      if (wr_ctl) begin
        filt_on_r <= wdata_in[CTL_FILT_BIT]; // RULE4
      end
      if (wr_en && hit(addr_in, ADDR_ICTL)) begin
        irq_en_r <= wdata_in[1:0]; // RULE12 RULE13
      end
    end
  end

  // Requests wait here until the engine takes them; a write beats the take
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      tx_req_r <= 1'b0;
      rx_req_r <= 1'b0;
    end else if (ce_in) begin
      if (!master_on_r) begin
        start_req_r <= 1'b0;
        stop_req_r <= 1'b0;
        tx_req_r <= 1'b0;
        rx_req_r <= 1'b0;
      end else begin
        if (wr_ctl && wdata_in[CTL_START_BIT]) begin
          start_req_r <= 1'b1; // RULE6
        end else if (go_start) begin
          start_req_r <= 1'b0;
        end
        if (wr_ctl && wdata_in[CTL_STOP_BIT]) begin
          stop_req_r <= 1'b1; // RULE5
        end else if (go_stop) begin
          stop_req_r <= 1'b0;
        end
        if (wr_dat && wdata_in[DAT_TXE_BIT]) begin
          tx_req_r <= 1'b1; // RULE9
        end else if (go_tx) begin
          tx_req_r <= 1'b0;
        end
        if (wr_dat && wdata_in[DAT_RXE_BIT]) begin
          rx_req_r <= 1'b1; // RULE8
        end else if (go_rx) begin
          rx_req_r <= 1'b0;
        end
      end
    end
  end

  // Byte field and acknowledge are frozen while a byte is on the wire
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      byte_r <= BYTE_RESET;
      ack_bit_r <= 1'b0;
      rx_rdy_r <= 1'b0;
    end else if (ce_in) begin
      if (rx_fin) begin
        byte_r <= shift_r; // RULE11
      end else if (wr_dat && !tx_busy && !rx_busy) begin
        byte_r <= wdata_in[7:0]; // RULE11
      end
      if (tx_fin) begin
        ack_bit_r <= ack_in_r; // RULE10
      end else if (wr_dat && !tx_busy && !rx_busy) begin
        ack_bit_r <= wdata_in[DAT_ACK_BIT]; // RULE10
      end
      if (rx_fin) begin
        rx_rdy_r <= 1'b1; // RULE7
      end else if (rd_dat || go_rx) begin
        rx_rdy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= IRQ_RESET;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_TX_BIT) ? tx_fin : rx_fin) begin
          irq_stat_r[i] <= 1'b1; // RULE15
        end else if (wr_en && hit(addr_in, ADDR_STATUS) && wdata_in[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
      irq_r <= |(irq_stat_r & irq_en_r); // RULE12 RULE13
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_r <= REG_RESET;
    end else if (ce_in) begin
      rdata_r <= rd_in ? read_word(addr_in) : REG_RESET;
    end
  end

  // Bus engine: four quarter periods per condition or bit
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      phase_r <= 2'd0;
      bit_cnt_r <= 4'h0;
      shift_r <= BYTE_RESET;
      is_rx_r <= 1'b0;
      ack_in_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (ce_in) begin
      if (!master_on_r) begin
        state_r <= ST_IDLE;
        phase_r <= 2'd0;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            phase_r <= 2'd0;
            bit_cnt_r <= 4'h0;
            if (go_start) begin
              state_r <= ST_START;
            end else if (go_tx || go_rx) begin
              state_r <= ST_BITS;
              is_rx_r <= go_rx;
              shift_r <= byte_r;
            end else if (go_stop && scl_low_r) begin
              // Only a bus this master holds can be stopped cleanly
              state_r <= ST_STOP;
            end
          end
          ST_START: begin
            if (tick) begin
              phase_r <= phase_r + 2'd1;
              unique case (phase_r)
                2'd0: sda_low_r <= 1'b0;
                2'd1: scl_low_r <= 1'b0;
                2'd2: sda_low_r <= 1'b1; // RULE6
                2'd3: begin
                  scl_low_r <= 1'b1;
                  state_r <= ST_IDLE;
                end
              endcase
            end
          end
          ST_BITS: begin
            if (tick) begin
              phase_r <= phase_r + 2'd1;
              unique case (phase_r)
                2'd0: begin
                  if (bit_cnt_r == 4'(LAST_BIT)) begin
                    sda_low_r <= is_rx_r && !ack_bit_r; // RULE10
                  end else begin
                    sda_low_r <= !is_rx_r && !shift_r[7]; // RULE16
                  end
                end
                2'd1: scl_low_r <= 1'b0;
                2'd2: begin
                  if (bit_cnt_r == 4'(LAST_BIT)) begin
                    ack_in_r <= line.sda; // RULE16
                  end else begin
                    shift_r <= {shift_r[6:0], line.sda};
                  end
                end
                2'd3: begin
                  scl_low_r <= 1'b1;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (byte_fin) begin
                    state_r <= ST_IDLE;
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (tick) begin
              phase_r <= phase_r + 2'd1;
              unique case (phase_r)
                2'd0: sda_low_r <= 1'b1;
                2'd1: scl_low_r <= 1'b0;
                2'd2: sda_low_r <= 1'b0; // RULE5
                2'd3: state_r <= ST_IDLE;
              endcase
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: pull low or release, never drive high
  assign scl_out = 1'b0; // RULE16
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_low_r;
  assign sda_oe_out = sda_low_r;
  assign rdata_out = rdata_r;
  assign irq_out = irq_r;
endmodule
`default_nettype wire

/* hw/imc_pkg.sv */
// Shared constants and types of the two-wire bus master
package imc_pkg;
  // Register addresses
  localparam logic [15:0] ADDR_ENABLE = 16'h4340;
  localparam logic [15:0] ADDR_CONTROL = 16'h4342;
  localparam logic [15:0] ADDR_DATA = 16'h4344;
  localparam logic [15:0] ADDR_ICTL = 16'h4346;
  localparam logic [15:0] ADDR_STATUS = 16'h4348;
  // Field positions
  localparam int EN_ON_BIT = 0;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_STOP_BIT = 1;
  localparam int CTL_FILT_BIT = 4;
  localparam int CTL_TXBUSY_BIT = 8;
  localparam int CTL_RXBUSY_BIT = 9;
  localparam int DAT_ACK_BIT = 8;
  localparam int DAT_TXE_BIT = 9;
  localparam int DAT_RXE_BIT = 10;
  localparam int DAT_RDY_BIT = 11;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Timing
  localparam int CLK_NS = 10;
  localparam int QTR_NS = 2500;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_NS = 40;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAST_BIT = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_BITS = 4'b0100,
    ST_STOP = 4'b1000
  } imc_state_t;
endpackage

/* hw/imc_quarter_timer.sv */
// Quarter bit period tick generator with clock stretch hold
`timescale 1ns/1ps
`default_nettype none
module imc_quarter_timer
  import imc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic hold_in,
  output logic tick_out
);
  logic [8:0] cnt_r;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt_r <= 9'h000;
    end else if (ce_in) begin
      if (!run_in || tick_out) begin
        cnt_r <= 9'h000;
      end else if (!hold_in) begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end

  assign tick_out = ce_in && run_in && !hold_in &&
                    (cnt_r == 9'(QTR_CYC - 1));
endmodule
`default_nettype wire

/* test/imc_master_monitor.sv */
// Port-level assertions for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module imc_master_monitor
  import imc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence start_cond;
    !scl_oe_out && $rose(sda_oe_out);
  endsequence
  sequence stop_cond;
    !scl_oe_out && $fell(sda_oe_out);
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in |=>
    rdata_out == 16'h0000 && !scl_oe_out && !sda_oe_out && !irq_out)
    else $error("outputs not cleared by reset");
  idle_read_a: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  enable_bits_a: assert property (rd_in && addr_in == ADDR_ENABLE |=>
    rdata_out[15:1] == 15'h0000) else $error("enable spare bits set");
  ctl_bits_a: assert property (rd_in && addr_in == ADDR_CONTROL |=>
    (rdata_out & 16'hfcec) == 16'h0000) else $error("control spare bits set");
  ictl_bits_a: assert property (rd_in && addr_in == ADDR_ICTL |=>
    rdata_out[15:2] == 14'h0000) else $error("irq enable spare bits set");
  start_then_clock_a: assert property (start_cond |->
    ##[240:260] scl_oe_out) else $error("clock not pulled after start");
  stop_released_a: assert property (stop_cond |=>
    (!scl_oe_out && !sda_oe_out) [*8]) else $error("lines not free after stop");
  mask_quiet_a: assert property (wr_in && addr_in == ADDR_ICTL &&
    wdata_in[1:0] == 2'h0 |-> ##2 !irq_out) else $error("masked irq raised");
  clear_quiet_a: assert property (wr_in && addr_in == ADDR_STATUS &&
    wdata_in[1:0] == 2'h3 |-> ##2 !irq_out) else $error("irq after clear");
  off_release_a: assert property (wr_in && addr_in == ADDR_ENABLE &&
    !wdata_in[0] |-> ##2 (!scl_oe_out && !sda_oe_out) [*4])
    else $error("lines held while disabled");
endmodule
bind imc_master_top imc_master_monitor i_mon (.clock_in, .rst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .scl_oe_out,
  .sda_oe_out, .irq_out);
`default_nettype wire

/* test/imc_slave_model.sv */
// Behavioural bus slave, one byte per start condition
`timescale 1ns/1ps
`default_nettype none
module imc_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic rd_mode_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic nack_in,
  output logic sda_pull_out,
  output logic [7:0] got_byte_out,
  output logic got_ack_out
);
  int bit_i = 9;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_pull_out = 1'b0;
    got_byte_out = 8'h00;
    got_ack_out = 1'b1;
  end
  // Start seen: next falling clock opens bit 0
  always @(negedge sda_in) begin
    if (scl_in) begin
      bit_i = -1;
    end
  end
  always @(posedge scl_in) begin
    if (bit_i >= 0 && bit_i < 8) begin
      sh = {sh[6:0], sda_in};
    end else if (bit_i == 8) begin
      got_byte_out = sh;
      got_ack_out = sda_in;
    end
  end
  // Data only moves while the clock is low
  always @(negedge scl_in) begin
    if (bit_i < 9) begin
      bit_i = bit_i + 1;
    end
    if (rd_mode_in) begin
      sda_pull_out = bit_i >= 0 && bit_i < 8 && !rd_byte_in[7 - bit_i];
    end else begin
      sda_pull_out = bit_i == 8 && !nack_in;
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import imc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] rdata;
  logic scl_oe, sda_oe, irq, s_pull, got_ack;
  logic scl_o, sda_o;
  logic ce = 1'b1;
  logic rd_mode = 1'b0;
  logic nack = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] got;
  logic [15:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  // Pull-ups: a released line reads high
  wire logic scl_w = !scl_oe;
  wire logic sda_w = !(sda_oe || s_pull);
  imc_master_top i_dut (.clock_in, .rst_n_in, .ce_in(ce), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq));
  imc_slave_model i_slave (.scl_in(scl_w), .sda_in(sda_w),
    .rd_mode_in(rd_mode), .rd_byte_in(rd_byte), .nack_in(nack),
    .sda_pull_out(s_pull), .got_byte_out(got), .got_ack_out(got_ack));
  initial begin
    forever #5 clock_in = !clock_in;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cyc(input logic w, input logic r, input logic [15:0] a,
                     input logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
  endtask
  task automatic wait_irq();
    int i;
    idle(1);
    for (i = 0; i < 30000 && irq !== 1'b1; i++) begin
      @(posedge clock_in);
    end
    if (irq !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_d) begin
      chk(exp_q.pop_front(), rdata);
    end
    rd_d <= rd;
  end
  initial begin
    logic [7:0] b;
    b = 8'($urandom(30854));
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    idle(1);
    rd_reg(ADDR_ENABLE, 16'h0000);
    rd_reg(ADDR_CONTROL, 16'h0000);
    rd_reg(ADDR_DATA, 16'h0000);
    rd_reg(ADDR_ICTL, 16'h0000);
    rd_reg(16'h434e, 16'h0000);
    wr_reg(ADDR_ENABLE, 16'hffff);
    rd_reg(ADDR_ENABLE, 16'h0001);
    wr_reg(ADDR_CONTROL, 16'hfffc);
    rd_reg(ADDR_CONTROL, 16'h0010);
    wr_reg(ADDR_ICTL, 16'hffff);
    rd_reg(ADDR_ICTL, 16'h0003);
    wr_reg(ADDR_DATA, 16'hf1a5);
    rd_reg(ADDR_DATA, 16'h01a5);
    // Frozen clock enable: the write below must not land
    idle(1);
    ce <= 1'b0;
    wr_reg(ADDR_ENABLE, 16'h0000);
    ce <= 1'b1;
    rd_reg(ADDR_ENABLE, 16'h0001);
    // Plain send, refused send, then a receive
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom());
      rd_mode = (k == 2);
      rd_byte = b;
      nack = (k == 1);
      wr_reg(ADDR_CONTROL, 16'h0011);
      wr_reg(ADDR_DATA, k == 2 ? 16'h0400 : {8'h02, b});
      rd_reg(ADDR_CONTROL, k == 2 ? 16'h0211 : 16'h0111);
      wr_reg(ADDR_CONTROL, 16'h0012);
      wait_irq();
      rd_reg(ADDR_STATUS, k == 2 ? 16'h0002 : 16'h0001);
      rd_reg(ADDR_DATA, {4'h0, k == 2, 2'h0, k == 1, b});
      rd_reg(ADDR_DATA, {7'h00, k == 1, b});
      wr_reg(ADDR_ICTL, k == 2 ? 16'h0001 : 16'h0002);
      idle(2);
      #1 chk({15'h0000, irq}, 16'h0000);
      wr_reg(ADDR_ICTL, 16'h0003);
      idle(2);
      #1 chk({15'h0000, irq}, 16'h0001);
      wr_reg(ADDR_STATUS, 16'h0003);
      idle(4 * QTR_CYC + 50);
      chk({14'h0000, scl_w, sda_w}, 16'h0003);
      chk({14'h0000, scl_o, sda_o}, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      if (k == 2) begin
        chk({15'h0000, got_ack}, 16'h0000);
      end else begin
        chk({8'h00, got}, {8'h00, b});
      end
    end
    wr_reg(ADDR_ENABLE, 16'h0000);
    wr_reg(ADDR_CONTROL, 16'h0011);
    rd_reg(ADDR_CONTROL, 16'h0010);
    idle(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
